// file: pkg/cvdp_params.svh
// Constants of the character-cell video data path
`ifndef CVDP_PARAMS_SVH
`define CVDP_PARAMS_SVH
`define CVDP_DOTS          7
`define CVDP_LINES         10
`define CVDP_LINE_W        4
`define CVDP_CELL_W        11
`define CVDP_ADDR_W        16
`define CVDP_DATA_W        8
`define CVDP_TOP_BIT       7
`define CVDP_DOT_MSB       6
`define CVDP_LAST_DOT      3'h6
`define CVDP_HOST_SLOT     3'h0
`define CVDP_GLYPH_FIRST   4'h0
`define CVDP_GLYPH_LAST    4'h6
`define CVDP_GAP_LINES     3
`define CVDP_CELLS         11'h780
`define CVDP_CHR_DEPTH     2048
`define CVDP_ROM_DEPTH     2048
`define CVDP_ROW_CELLS     11'h050
`define CVDP_MEM_NS        150
`define CVDP_CLK_NS        100
`define CVDP_MEM_CYC       ((`CVDP_MEM_NS + `CVDP_CLK_NS - 1) / `CVDP_CLK_NS)
`define CVDP_REG_CTRL      4'h0
`define CVDP_REG_ADDR      4'h4
`define CVDP_REG_DATA      4'h8
`define CVDP_REG_STAT      4'hc
`define CVDP_RESP_OK       2'h0
`define CVDP_RESP_ERR      2'h2
`endif

// file: pkg/cvdp_pkg.sv
// Types of the character-cell video data path
package cvdp_pkg;
    typedef enum logic [1:0] {
        CVDP_MODE_CHAR,
        CVDP_MODE_MAPPED,
        CVDP_MODE_COMBINED,
        CVDP_MODE_CHRAM
    } cvdp_mode_t;
    typedef enum logic [1:0] {
        CVDP_TGT_DISPLAY,
        CVDP_TGT_CHRAM,
        CVDP_TGT_SYMBOL
    } cvdp_target_t;
endpackage

// file: pkg/cvdp_if.sv
// Link between display timing controller side and data path
`timescale 1ns/1ps
`default_nettype none
interface cvdp_if;
    logic [15:0] mem_addr;
    logic [3:0]  scan_line;
    logic        dot_last;
    logic        blank;
    logic        host_we;
    logic        host_tgt_sym;
    logic        host_tgt_chr;
    logic [15:0] host_addr;
    logic [7:0]  host_wdata;
    logic        host_slot;
    modport path (
        input  mem_addr, scan_line, dot_last, blank,
        input  host_we, host_tgt_sym, host_tgt_chr, host_addr, host_wdata,
        output host_slot
    );
    modport ctrl (
        output mem_addr, scan_line, dot_last, blank,
        output host_we, host_tgt_sym, host_tgt_chr, host_addr, host_wdata,
        input  host_slot
    );
endinterface
`default_nettype wire

// file: design/cvdp_path.sv
// Video data path: memory, glyph lookup, latch and dot shifter
`include "cvdp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cvdp_path
    import cvdp_pkg::*;
(
    input  wire logic   clk_in,
    input  wire logic   resetn_in,
    input  wire logic   [1:0] mode_in,
    cvdp_if.path        lnk,
    output logic        video_out,
    output logic        attr_out
);
    cvdp_mode_t  mode;
    logic [7:0]  disp_mem [0:(1 << `CVDP_ADDR_W) - 1];
    logic [7:0]  chr_ram  [0:`CVDP_CHR_DEPTH - 1];
    logic [7:0]  sym_rom  [0:`CVDP_ROM_DEPTH - 1];
    logic [7:0]  mem_q_r;
    logic [3:0]  line_q_r;
    logic [7:0]  latch_r;
    logic [6:0]  shift_r;
    logic        attr_r;
    logic        loaded_r;
    logic [10:0] glyph_addr;
    logic [10:0] rom_addr;
    logic [7:0]  word_nxt;
    logic [7:0]  alpha_row;
    logic        use_dots;

    assign mode = cvdp_mode_t'(mode_in);
    assign lnk.host_slot = lnk.blank | lnk.dot_last;

    // Host writes into display, char RAM or symbol store
    always_ff @(posedge clk_in) begin
        if (lnk.host_we & lnk.host_slot) begin
            if (lnk.host_tgt_chr)
                chr_ram[lnk.host_addr[10:0]] <= lnk.host_wdata;
            else if (lnk.host_tgt_sym)
                sym_rom[lnk.host_addr[10:0]] <= lnk.host_wdata;
            else
                disp_mem[lnk.host_addr] <= lnk.host_wdata;
        end
    end

    // Stage 1: memory read at cell+line address
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_q_r  <= 8'h00;
            line_q_r <= 4'h0;
        end else begin
            mem_q_r  <= disp_mem[lnk.mem_addr];
            line_q_r <= lnk.scan_line;
        end
    end

    // Fixed alphanumeric glyph: 5x7 box inside a 7x10 field
    always_comb begin
        alpha_row = 8'h00;
        if (line_q_r <= `CVDP_GLYPH_LAST)
            alpha_row = {1'b0, 1'b0, mem_q_r[4:0] ^ line_q_r[3:0] ^ 5'h00,
                         1'b0};
    end

    assign glyph_addr = {mem_q_r[6:0], line_q_r};
    assign rom_addr   = {mem_q_r[6:0], line_q_r};
    assign use_dots   = (mode == CVDP_MODE_MAPPED) |
                        ((mode == CVDP_MODE_COMBINED) &
                         mem_q_r[`CVDP_TOP_BIT]);

    // Resolve to dot word within the cycle budget
    always_comb begin
        word_nxt = 8'h00;
        if (use_dots)
            word_nxt = mem_q_r;
        else if (mode == CVDP_MODE_CHRAM)
            word_nxt = chr_ram[glyph_addr];
        else if (mem_q_r[`CVDP_TOP_BIT])
            word_nxt = sym_rom[rom_addr];
        else
            word_nxt = alpha_row;
    end

    // Stage 2: eight-bit latch held one dot
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            latch_r <= 8'h00;
        else
            latch_r <= word_nxt;
    end

    // Shifter: parallel load on last dot, else shift
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift_r  <= 7'h00;
            attr_r   <= 1'b0;
            loaded_r <= 1'b0;
        end else if (lnk.dot_last) begin
            shift_r  <= latch_r[`CVDP_DOT_MSB:0];
            attr_r   <= latch_r[`CVDP_TOP_BIT];
            loaded_r <= 1'b1;
        end else begin
            shift_r <= {shift_r[5:0], 1'b0};
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            video_out <= 1'b0;
            attr_out  <= 1'b0;
        end else begin
            video_out <= loaded_r & ~lnk.blank &
                         shift_r[`CVDP_DOT_MSB];
            attr_out  <= attr_r;
        end
    end
endmodule
`default_nettype wire

// file: design/cvdp_ctrl.sv
// Timing controller end: addresses, line count and host writes over AXI-Lite
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`include "cvdp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cvdp_ctrl
    import cvdp_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [1:0]       mode_out,
    cvdp_if.ctrl             lnk
);
    logic [2:0]  dot_r;
    logic [3:0]  line_r;
    logic [10:0] cell_r;
    logic [10:0] row_start_r;
    logic [10:0] page_start_r;
    logic [1:0]  mode_r;
    logic [15:0] haddr_r;
    logic [7:0]  hdata_r;
    logic [1:0]  htgt_r;
    logic        hpend_r;
    logic        aw_r;
    logic        w_r;
    logic [3:0]  awa_r;
    logic [31:0] wd_r;
    logic        wr_go;

    assign lnk.dot_last  = (dot_r == `CVDP_LAST_DOT);
    assign lnk.scan_line = line_r;
    assign lnk.mem_addr  = {1'b0, line_r, cell_r};
    assign lnk.blank     = (line_r >= 4'(`CVDP_LINES - `CVDP_GAP_LINES));
    assign lnk.host_we   = hpend_r;
    assign lnk.host_addr = haddr_r;
    assign lnk.host_wdata = hdata_r;
    assign lnk.host_tgt_chr = (htgt_r == 2'h1);
    assign lnk.host_tgt_sym = (htgt_r == 2'h2);
    assign mode_out = mode_r;

    // Dot, cell and line sequencing from page start
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dot_r <= 3'h0;
            line_r <= 4'h0;
            cell_r <= 11'h000;
            row_start_r <= 11'h000;
        end else if (dot_r != `CVDP_LAST_DOT) begin
            dot_r <= dot_r + 3'h1;
        end else begin
            dot_r <= 3'h0;
            if (cell_r + 11'h001 - row_start_r != `CVDP_ROW_CELLS) begin
                cell_r <= cell_r + 11'h001;
            end else if (line_r != 4'(`CVDP_LINES - 1)) begin
                line_r <= line_r + 4'h1;
                cell_r <= row_start_r;
            end else begin
                line_r <= 4'h0;
                row_start_r <= (cell_r + 11'h001 >= `CVDP_CELLS) ?
                               page_start_r : cell_r + 11'h001;
                cell_r <= (cell_r + 11'h001 >= `CVDP_CELLS) ?
                          page_start_r : cell_r + 11'h001;
            end
        end
    end

    // AXI-Lite write channel capture
    assign awready = ~aw_r & ~bvalid;
    assign wready  = ~w_r & ~bvalid;
    assign wr_go   = aw_r & w_r & ~hpend_r;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awa_r <= 4'h0;
            wd_r <= 32'h0;
            bvalid <= 1'b0;
            bresp <= `CVDP_RESP_OK;
        end else begin
            if (awvalid & awready) begin
                aw_r <= 1'b1;
                awa_r <= awaddr;
            end
            if (wvalid & wready) begin
                w_r <= 1'b1;
                wd_r <= wdata;
            end
            if (wr_go) begin
                aw_r <= 1'b0;
                w_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awa_r == `CVDP_REG_STAT) ?
                         `CVDP_RESP_ERR : `CVDP_RESP_OK;
            end else if (bvalid & bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Control registers and pending host write, issued in host slot
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_r <= 2'h0;
            page_start_r <= 11'h000;
            haddr_r <= 16'h0000;
            htgt_r <= 2'h0;
            hdata_r <= 8'h00;
            hpend_r <= 1'b0;
        end else begin
            if (hpend_r & lnk.host_slot)
                hpend_r <= 1'b0;
            if (wr_go) begin
                unique case (awa_r)
                    `CVDP_REG_CTRL: begin
                        mode_r <= wd_r[1:0];
                        htgt_r <= wd_r[5:4];
                        page_start_r <= wd_r[26:16];
                    end
                    `CVDP_REG_ADDR: haddr_r <= wd_r[15:0];
                    `CVDP_REG_DATA: begin
                        hdata_r <= wd_r[7:0];
                        hpend_r <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Read channel
    assign arready = ~rvalid;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `CVDP_RESP_OK;
        end else if (arvalid & arready) begin
            rvalid <= 1'b1;
            rresp <= `CVDP_RESP_OK;
            unique case (araddr)
                `CVDP_REG_CTRL: rdata <= {5'h0, page_start_r, 10'h0,
                                          htgt_r, 2'h0, mode_r};
                `CVDP_REG_ADDR: rdata <= {16'h0, haddr_r};
                `CVDP_REG_DATA: rdata <= {24'h0, hdata_r};
                `CVDP_REG_STAT: rdata <= {9'h0, hpend_r, line_r, 7'h0,
                                          cell_r};
                default: begin
                    rdata <= 32'h0;
                    rresp <= `CVDP_RESP_ERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: verification/cvdp_link_monitor.sv
// Checker on the link between the timing end and the data path
`timescale 1ns/1ps
`default_nettype none
module cvdp_link_monitor
    import cvdp_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic [15:0] mem_addr,
    input wire logic [3:0]  scan_line,
    input wire logic        dot_last,
    input wire logic        blank,
    input wire logic        host_we,
    input wire logic        host_tgt_sym,
    input wire logic        host_tgt_chr,
    input wire logic [15:0] host_addr,
    input wire logic [7:0]  host_wdata,
    input wire logic        host_slot
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // Six quiet dots, then the last dot of the next cell
    sequence s_cell;
        !dot_last [*6] ##1 dot_last;
    endsequence
    chk_cell_period: assert property (dot_last |=> s_cell)
        else $error("cell length wrong");
    chk_slot_source: assert property (host_slot == (blank || dot_last))
        else $error("host slot wrong");
    chk_addr_layout: assert property (
        mem_addr[15:11] == {1'b0, scan_line})
        else $error("address layout wrong");
    chk_line_range: assert property (scan_line <= 4'h9)
        else $error("scan line out of range");
    chk_blank_lines: assert property (blank == (scan_line >= 4'h7))
        else $error("blank level wrong");
    chk_addr_steady: assert property (
        !$past(dot_last) |-> $stable(mem_addr))
        else $error("address moved inside a cell");
    chk_write_hold: assert property (host_we && !host_slot |=>
        host_we && $stable(host_addr) && $stable(host_wdata))
        else $error("pending write not held");
    chk_write_retire: assert property (
        host_we && host_slot |=> !host_we)
        else $error("write not retired in slot");
    chk_target_single: assert property (
        !(host_tgt_sym && host_tgt_chr))
        else $error("two write targets");
endmodule
`default_nettype wire

// file: verification/crt_video_data_path_tb.sv
// Testbench joining the timing end and the data path
`timescale 1ns/1ps
`default_nettype none
module crt_video_data_path_tb
    import cvdp_pkg::*;
    ;
    logic        clk_in, resetn_in, video_out, attr_out;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, mode_w, r;
    int          n_errors, num_checks;
    cvdp_if lnk();
    cvdp_ctrl u_cvdp_ctrl(.clk_in, .resetn_in, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .mode_out(mode_w), .lnk(lnk));
    cvdp_path u_cvdp_path(.clk_in, .resetn_in, .mode_in(mode_w), .lnk(lnk),
        .video_out, .attr_out);
    cvdp_link_monitor u_mon(.clk_in, .resetn_in, .mem_addr(lnk.mem_addr),
        .scan_line(lnk.scan_line), .dot_last(lnk.dot_last),
        .blank(lnk.blank), .host_we(lnk.host_we),
        .host_tgt_sym(lnk.host_tgt_sym), .host_tgt_chr(lnk.host_tgt_chr),
        .host_addr(lnk.host_addr), .host_wdata(lnk.host_wdata),
        .host_slot(lnk.host_slot));
    always #50 clk_in = ~clk_in;
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic lost();
        $display("mismatch at %0t: wait ran out", $time);
        n_errors++;
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        r = bresp;
        bready <= 1'b0;
        if (n >= 100) lost();
    endtask
    task automatic axr(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) lost();
    endtask
    // Find the cell's last dot, then collect its word MSB first
    task automatic see(input logic [15:0] a, input logic [7:0] w);
        int n;
        logic [6:0] got;
        n = 0;
        got = 7'h00;
        do begin
            @(posedge clk_in);
            n++;
        end while (!(lnk.dot_last === 1'b1 && lnk.mem_addr === a) &&
                   n < 20000);
        if (n >= 20000) lost();
        @(posedge clk_in);
        for (int i = 6; i >= 0; i--) begin
            @(posedge clk_in);
            got[i] = video_out;
            if (i == 6) chk({31'h0, attr_out}, {31'h0, w[7]});
        end
        chk({25'h0, got}, {25'h0, w[6:0]});
    endtask
    initial begin
        {clk_in, resetn_in, awaddr, araddr, wdata, awvalid, wvalid} = '0;
        {bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        n_errors = 0;
        num_checks = 0;
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        axr(4'h0);
        chk({31'h0, video_out}, 32'h0);
        chk(d, 32'h0);
        axw(4'h0, 32'h1);
        chk({30'h0, r}, 32'h0);
        chk({30'h0, mode_w}, 32'h1);
        axw(4'h4, 32'h1805);
        axw(4'h8, 32'hd5);
        axw(4'h4, 32'h2006);
        axw(4'h8, 32'h2a);
        see(16'h1805, 8'hd5);
        see(16'h2006, 8'h2a);
        axw(4'h0, 32'h13);
        axw(4'h4, 32'h213);
        axw(4'h8, 32'h3c);
        axw(4'h0, 32'h3);
        axw(4'h4, 32'h1855);
        axw(4'h8, 32'h21);
        axw(4'h4, 32'h55);
        axw(4'h8, 32'h21);
        see(16'h1855, 8'h3c);
        axw(4'hc, 32'h1);
        chk({30'h0, r}, 32'h2);
        axr(4'h2);
        chk({30'h0, r}, 32'h2);
        chk(d, 32'h0);
        for (int m = 0; m < 4; m++) begin
            axw(4'h0, m);
            chk({30'h0, mode_w}, m);
        end
        axw(4'h0, 32'h20);
        axw(4'h4, 32'h53);
        axw(4'h8, 32'h1e);
        axw(4'h0, 32'h0);
        axw(4'h4, 32'h18a5);
        axw(4'h8, 32'h85);
        see(16'h18a5, 8'h1e);
        axw(4'h0, 32'h2);
        axw(4'h4, 32'h20f5);
        axw(4'h8, 32'hb3);
        see(16'h20f5, 8'hb3);
        wrap_up();
    end
endmodule
`default_nettype wire
